// [tbpc_pkg.sv]
// package: shared constants and types for the transient burst panel control
package tbpc_pkg;

    // ------------------------------------------------------------------
    // clock and timing
    // ------------------------------------------------------------------
    localparam int unsigned CLK_HZ = 100_000_000;
    localparam int unsigned CLK_PER_US = CLK_HZ / 1_000_000;
    localparam int unsigned SAFETY_TIME_MIN = 15;
    localparam longint unsigned SAFETY_CYCLES = 64'(SAFETY_TIME_MIN) * 60 * CLK_HZ;
    localparam int unsigned BURST_LONG_MS = 15;
    localparam int unsigned BURST_SHORT_MS = 1;
    localparam int unsigned BURST_PERIOD_MS = 300;
    localparam int unsigned BURST_LONG_CYCLES = BURST_LONG_MS * 1000 * CLK_PER_US;
    localparam int unsigned BURST_SHORT_CYCLES = BURST_SHORT_MS * 1000 * CLK_PER_US;
    localparam int unsigned BURST_PERIOD_CYCLES = BURST_PERIOD_MS * 1000 * CLK_PER_US;
    // pulse spacing in ns for each rate
    localparam int unsigned SPACING_2K5_NS = 400_000;
    localparam int unsigned SPACING_5K_NS = 200_000;
    localparam int unsigned SPACING_10K_NS = 100_000;
    localparam int unsigned SPACING_100K_NS = 10_000;
    localparam int unsigned CLK_PERIOD_NS = 1_000_000_000 / CLK_HZ;
    localparam int unsigned SPACING_2K5_CYCLES = SPACING_2K5_NS / CLK_PERIOD_NS;
    localparam int unsigned SPACING_5K_CYCLES = SPACING_5K_NS / CLK_PERIOD_NS;
    localparam int unsigned SPACING_10K_CYCLES = SPACING_10K_NS / CLK_PERIOD_NS;
    localparam int unsigned SPACING_100K_CYCLES = SPACING_100K_NS / CLK_PERIOD_NS;

    // ------------------------------------------------------------------
    // register map (offsets chosen for this block)
    // ------------------------------------------------------------------
    localparam logic [11:0] CTRL_OFF = 12'h000;
    localparam logic [11:0] STATUS_OFF = 12'h004;
    // ctrl write bits: one-shot button presses
    localparam int CTRL_RUN_BIT = 0;
    localparam int CTRL_STOP_BIT = 1;
    localparam int CTRL_POL_BIT = 2;
    localparam int CTRL_BYP_BIT = 3;
    localparam int CTRL_RESET_BIT = 4;
    localparam int CTRL_LINE_BIT = 8;
    localparam int CTRL_NEUT_BIT = 9;
    localparam int CTRL_EARTH_BIT = 10;
    localparam int CTRL_CABLE_BIT = 11;
    localparam int CTRL_RATE_LSB = 12; // 4 bits, one per rate
    // status read bits
    localparam int ST_RUN_BIT = 0;
    localparam int ST_STOP_BIT = 1;
    localparam int ST_POS_BIT = 2;
    localparam int ST_NEG_BIT = 3;
    localparam int ST_BYP_BIT = 4;
    localparam int ST_LINE_BIT = 8;
    localparam int ST_NEUT_BIT = 9;
    localparam int ST_EARTH_BIT = 10;
    localparam int ST_CABLE_BIT = 11;
    localparam int ST_RATE_LSB = 12;
    localparam int ST_BURST_BIT = 16;

    // ------------------------------------------------------------------
    // rates and reset values
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {RATE_2K5, RATE_5K, RATE_10K, RATE_100K} tbpc_rate_t;
    localparam tbpc_rate_t RATE_RESET = RATE_2K5;
    localparam logic POL_NEG_RESET = 1'b0;
    localparam logic BYP_RESET = 1'b0;
    localparam logic [3:0] LEADS_RESET = 4'h0;

endpackage : tbpc_pkg

// [tbpc_button_sync.sv]
// two-flop synchroniser and rising-edge press detector for panel buttons
`timescale 1ns/1ps
module tbpc_button_sync #(
    parameter int WIDTH = 9
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [WIDTH-1:0] btn_in,
    output logic [WIDTH-1:0] press
);
    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] sync_reg;
    logic [WIDTH-1:0] last_reg;

    // ----------------------------------------------------------------
    // synchroniser and edge detect
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_reg <= '0;
            sync_reg <= '0;
            last_reg <= '0;
        end else begin
            meta_reg <= btn_in;
            sync_reg <= meta_reg;
            last_reg <= sync_reg;
        end
    end

    assign press = sync_reg & ~last_reg; // one pulse per press
endmodule : tbpc_button_sync

// [tbpc_burst_gen.sv]
// burst timing: pulse spacing, burst width and burst period counters
`timescale 1ns/1ps
module tbpc_burst_gen
    import tbpc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic running,
    input wire tbpc_rate_t rate,
    output logic trigger,
    output logic in_burst
);
    logic [31:0] period_reg, period_next;
    logic [31:0] space_reg, space_next;
    logic active_reg, active_next;
    logic trig_reg, trig_next;
    logic [31:0] width_c;
    logic [31:0] spacing_c;

    // ----------------------------------------------------------------
    // per-rate burst width and pulse spacing
    // ----------------------------------------------------------------
    always_comb begin
        case (rate)
            RATE_2K5: begin
                width_c = BURST_LONG_CYCLES;
                spacing_c = SPACING_2K5_CYCLES;
            end
            RATE_5K: begin
                width_c = BURST_LONG_CYCLES;
                spacing_c = SPACING_5K_CYCLES;
            end
            RATE_10K: begin
                width_c = BURST_SHORT_CYCLES;
                spacing_c = SPACING_10K_CYCLES;
            end
            default: begin
                width_c = BURST_SHORT_CYCLES;
                spacing_c = SPACING_100K_CYCLES;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // counters: period restarts every 300 ms, pulse on spacing wrap
    // ----------------------------------------------------------------
    always_comb begin
        period_next = period_reg;
        space_next = space_reg;
        active_next = active_reg;
        trig_next = 1'b0;
        if (!running) begin
            period_next = '0;
            space_next = '0;
            active_next = 1'b0;
        end else if (!active_reg && period_reg == 32'h0) begin
            active_next = 1'b1;
            trig_next = 1'b1; // first pulse opens the burst
            space_next = '0;
            period_next = 32'h1;
        end else begin
            if (period_reg == BURST_PERIOD_CYCLES - 1) begin
                period_next = '0;
                active_next = 1'b0;
            end else begin
                period_next = period_reg + 32'h1;
            end
            if (active_reg && period_reg >= width_c) begin
                active_next = 1'b0; // width reached
            end
            if (active_reg && period_reg < width_c) begin
                if (space_reg >= spacing_c - 1) begin
                    space_next = '0;
                    trig_next = 1'b1;
                end else begin
                    space_next = space_reg + 32'h1;
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            period_reg <= '0;
            space_reg <= '0;
            active_reg <= 1'b0;
            trig_reg <= 1'b0;
        end else begin
            period_reg <= period_next;
            space_reg <= space_next;
            active_reg <= active_next;
            trig_reg <= trig_next;
        end
    end

    assign trigger = trig_reg;
    assign in_burst = active_reg;
endmodule : tbpc_burst_gen

// [tbpc_panel_ctrl.sv]
// top level: panel buttons, apb register access, run state and relays
`timescale 1ns/1ps
module tbpc_panel_ctrl
    import tbpc_pkg::*;
#(
    parameter longint unsigned SAFETY_LIMIT = SAFETY_CYCLES
) (
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // panel pushbuttons, active high while held
    input wire logic run_btn,
    input wire logic stop_btn,
    input wire logic polarity_btn,
    input wire logic bypass_btn,
    input wire logic reset_btn,
    input wire logic line_btn,
    input wire logic neutral_btn,
    input wire logic earth_btn,
    input wire logic cable_btn,
    input wire logic [3:0] rate_btn,
    // lamps
    output logic run_lamp,
    output logic stop_lamp,
    output logic pos_lamp,
    output logic neg_lamp,
    output logic bypass_lamp,
    output logic [3:0] rate_lamp,
    // relay matrix and trigger
    output logic line_relay,
    output logic neutral_relay,
    output logic earth_lead_select,
    output logic cable_port_select,
    output logic polarity_neg,
    output logic pulse_trigger,
    output logic burst_active
);
    localparam int NBTN = 13;

    logic [NBTN-1:0] btn_press;
    logic [NBTN-1:0] sw_press;
    logic [NBTN-1:0] ev;
    logic run_reg, run_next;
    logic neg_reg, neg_next;
    logic byp_reg, byp_next;
    tbpc_rate_t rate_reg, rate_next;
    logic [3:0] lead_reg, lead_next; // line, neutral, earth, cable
    logic [63:0] timer_reg, timer_next;
    logic [31:0] rdata_reg, rdata_next;
    logic apb_wr;
    logic apb_rd;
    logic addr_ok;
    logic trig_w;
    logic burst_w;

    // one-hot lamp pattern for a rate
    function automatic logic [3:0] rate_onehot(input tbpc_rate_t r);
        rate_onehot = 4'h1 << r;
    endfunction : rate_onehot

    // ----------------------------------------------------------------
    // panel button conditioning
    // ----------------------------------------------------------------
    // panel levels are asynchronous; two flops keep metastability out
    tbpc_button_sync #(
        .WIDTH(NBTN)
    ) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .btn_in({rate_btn, cable_btn, earth_btn, neutral_btn, line_btn,
                 reset_btn, bypass_btn, polarity_btn, stop_btn, run_btn}),
        .press(btn_press)
    );

    // ----------------------------------------------------------------
    // apb slave: zero wait states, error on unmapped address
    // ----------------------------------------------------------------
    // every access ends in one cycle, so pready is tied high
    assign addr_ok = (paddr == CTRL_OFF) || (paddr == STATUS_OFF);
    assign apb_wr = psel && penable && pwrite && (paddr == CTRL_OFF);
    assign apb_rd = psel && !penable && !pwrite;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !addr_ok;

    // software presses mapped onto the same event bits as buttons
    always_comb begin
        sw_press = '0;
        if (apb_wr) begin
            sw_press = {pwdata[CTRL_RATE_LSB +: 4], pwdata[CTRL_CABLE_BIT],
                        pwdata[CTRL_EARTH_BIT], pwdata[CTRL_NEUT_BIT],
                        pwdata[CTRL_LINE_BIT], pwdata[CTRL_RESET_BIT],
                        pwdata[CTRL_BYP_BIT], pwdata[CTRL_POL_BIT],
                        pwdata[CTRL_STOP_BIT], pwdata[CTRL_RUN_BIT]};
        end
    end
    // panel and software press in one cycle count once
    assign ev = btn_press | sw_press;

    // read data captured in setup phase, status from live state
    always_comb begin
        rdata_next = rdata_reg;
        if (apb_rd) begin
            rdata_next = '0;
            if (paddr == STATUS_OFF) begin
                rdata_next[ST_RUN_BIT] = run_reg;
                rdata_next[ST_STOP_BIT] = !run_reg;
                rdata_next[ST_POS_BIT] = !neg_reg;
                rdata_next[ST_NEG_BIT] = neg_reg;
                rdata_next[ST_BYP_BIT] = byp_reg;
                rdata_next[ST_LINE_BIT] = lead_reg[0];
                rdata_next[ST_NEUT_BIT] = lead_reg[1];
                rdata_next[ST_EARTH_BIT] = lead_reg[2];
                rdata_next[ST_CABLE_BIT] = lead_reg[3];
                rdata_next[ST_RATE_LSB +: 4] = rate_onehot(rate_reg);
                rdata_next[ST_BURST_BIT] = burst_w;
            end
        end
    end

    // ----------------------------------------------------------------
    // run state and safety timer
    // ----------------------------------------------------------------
    // reset beats all; stop beats run if both arrive together
    always_comb begin
        run_next = run_reg;
        timer_next = timer_reg;
        if (ev[4]) begin
            run_next = 1'b0;
            timer_next = '0;
        end else if (ev[1]) begin
            run_next = 1'b0;
        end else if (ev[0] && !run_reg) begin
            run_next = 1'b1;
            timer_next = '0;
        end else if (run_reg && !byp_reg) begin
            if (timer_reg >= SAFETY_LIMIT - 1) begin
                run_next = 1'b0;
            end else begin
                timer_next = timer_reg + 64'h1;
            end
        end
    end

    // run registers; a held timer resumes when bypass goes off
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_reg <= 1'b0;
            timer_reg <= '0;
        end else begin
            run_reg <= run_next;
            timer_reg <= timer_next;
        end
    end

    // ----------------------------------------------------------------
    // panel settings: polarity, bypass and rate
    // ----------------------------------------------------------------
    always_comb begin
        neg_next = neg_reg;
        byp_next = byp_reg;
        rate_next = rate_reg;
        if (ev[4]) begin
            neg_next = POL_NEG_RESET;
            byp_next = BYP_RESET;
            rate_next = RATE_RESET;
        end else begin
            if (ev[2]) begin
                neg_next = !neg_reg;
            end
            if (ev[3]) begin
                byp_next = !byp_reg;
            end
            // lowest-numbered rate button wins a tie
            if (ev[9]) begin
                rate_next = RATE_2K5;
            end else if (ev[10]) begin
                rate_next = RATE_5K;
            end else if (ev[11]) begin
                rate_next = RATE_10K;
            end else if (ev[12]) begin
                rate_next = RATE_100K;
            end
        end
    end

    // settings registers; power-up equals the reset defaults
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            neg_reg <= POL_NEG_RESET;
            byp_reg <= BYP_RESET;
            rate_reg <= RATE_RESET;
        end else begin
            neg_reg <= neg_next;
            byp_reg <= byp_next;
            rate_reg <= rate_next;
        end
    end

    // ----------------------------------------------------------------
    // coupling relays: leads toggle independently, cable excludes them
    // ----------------------------------------------------------------
    // a lead press beats a cable press in the same cycle
    always_comb begin
        lead_next = lead_reg;
        if (ev[4]) begin
            lead_next = LEADS_RESET;
        end else if (ev[5] || ev[6] || ev[7]) begin
            lead_next[0] = lead_reg[0] ^ ev[5];
            lead_next[1] = lead_reg[1] ^ ev[6];
            lead_next[2] = lead_reg[2] ^ ev[7];
            if (lead_next[2:0] != 3'h0) begin
                lead_next[3] = 1'b0;
            end
        end else if (ev[8]) begin
            lead_next[3] = !lead_reg[3];
            if (!lead_reg[3]) begin
                lead_next[2:0] = 3'h0;
            end
        end
    end

    // coupling registers; all relays open at power-up
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lead_reg <= LEADS_RESET;
        end else begin
            lead_reg <= lead_next;
        end
    end

    // read data register; holds until the next read setup
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_reg <= '0;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    // ----------------------------------------------------------------
    // burst timing
    // ----------------------------------------------------------------
    // a new burst opens with a pulse whenever running starts
    tbpc_burst_gen u_burst (
        .pclk(pclk),
        .presetn(presetn),
        .running(run_reg),
        .rate(rate_reg),
        .trigger(trig_w),
        .in_burst(burst_w)
    );

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    // lamps and relays follow the state registers directly
    assign prdata = rdata_reg;
    assign run_lamp = run_reg;
    assign stop_lamp = !run_reg;
    assign pos_lamp = !neg_reg;
    assign neg_lamp = neg_reg;
    assign bypass_lamp = byp_reg;
    assign rate_lamp = rate_onehot(rate_reg);
    assign line_relay = lead_reg[0];
    assign neutral_relay = lead_reg[1];
    assign earth_lead_select = lead_reg[2];
    assign cable_port_select = lead_reg[3];
    assign polarity_neg = neg_reg;
    assign pulse_trigger = trig_w;
    assign burst_active = burst_w;
endmodule : tbpc_panel_ctrl

// [tbpc_operator.sv]
// operator model: pushbuttons held down for a few cycles per press
`timescale 1ns/1ps
module tbpc_operator (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [12:0] press_req,
    output logic [12:0] btn
);
    logic [12:0] btn_reg, btn_next;
    logic [2:0] hold_reg, hold_next;

    // hold each press past the synchroniser, then release to low
    always_comb begin
        btn_next = btn_reg;
        hold_next = hold_reg;
        if (press_req != 13'h0) begin
            btn_next = press_req;
            hold_next = 3'h4;
        end else if (hold_reg != 3'h0) begin
            hold_next = hold_reg - 3'h1;
        end else begin
            btn_next = 13'h0;
        end
    end

    // button state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            btn_reg <= 13'h0;
            hold_reg <= 3'h0;
        end else begin
            btn_reg <= btn_next;
            hold_reg <= hold_next;
        end
    end

    assign btn = btn_reg;
endmodule : tbpc_operator

// [tbpc_panel_ctrl_properties.sv]
// checker: temporal properties of the panel control outputs
`timescale 1ns/1ps
module tbpc_panel_ctrl_properties #(
    parameter longint unsigned SAFETY_LIMIT = 1000
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic run_lamp,
    input wire logic stop_lamp,
    input wire logic pos_lamp,
    input wire logic neg_lamp,
    input wire logic bypass_lamp,
    input wire logic [3:0] rate_lamp,
    input wire logic line_relay,
    input wire logic neutral_relay,
    input wire logic earth_lead_select,
    input wire logic cable_port_select,
    input wire logic polarity_neg,
    input wire logic pulse_trigger,
    input wire logic burst_active
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    longint unsigned run_cnt_reg;

    // running time without bypass, as the safety timer sees it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_cnt_reg <= 0;
        end else if (!run_lamp) begin
            run_cnt_reg <= 0;
        end else if (!bypass_lamp) begin
            run_cnt_reg <= run_cnt_reg + 1;
        end
    end

    sequence s_burst_open;
        pulse_trigger && burst_active;
    endsequence

    a_stop_lamp: assert property (stop_lamp != run_lamp)
        else $error("stop lamp not the inverse of run lamp");
    a_pol_lamps: assert property (pos_lamp != neg_lamp && neg_lamp == polarity_neg)
        else $error("polarity lamps disagree with relay");
    a_rate_onehot: assert property ($onehot(rate_lamp))
        else $error("rate lamps not one-hot");
    a_cable_excl: assert property (cable_port_select |->
        !(line_relay || neutral_relay || earth_lead_select))
        else $error("cable output together with a lead");
    a_reset_dflt: assert property ($rose(presetn) |-> !run_lamp && pos_lamp
        && !bypass_lamp && rate_lamp == 4'h1 && !line_relay && !cable_port_select)
        else $error("defaults wrong after reset");
    a_run_opens: assert property ($rose(run_lamp) |=> s_burst_open)
        else $error("run did not open a burst with a pulse");
    a_idle_quiet: assert property (!run_lamp |=> !pulse_trigger)
        else $error("trigger while stopped");
    a_trig_single: assert property (pulse_trigger |=> !pulse_trigger)
        else $error("trigger longer than one cycle");
    a_safety_cap: assert property (run_cnt_reg <= SAFETY_LIMIT + 4)
        else $error("safety timer did not stop the run");
endmodule : tbpc_panel_ctrl_properties

bind tbpc_panel_ctrl tbpc_panel_ctrl_properties #(.SAFETY_LIMIT(SAFETY_LIMIT)) u_props (
    .pclk(pclk), .presetn(presetn), .run_lamp(run_lamp), .stop_lamp(stop_lamp),
    .pos_lamp(pos_lamp), .neg_lamp(neg_lamp), .bypass_lamp(bypass_lamp),
    .rate_lamp(rate_lamp), .line_relay(line_relay), .neutral_relay(neutral_relay),
    .earth_lead_select(earth_lead_select), .cable_port_select(cable_port_select),
    .polarity_neg(polarity_neg), .pulse_trigger(pulse_trigger),
    .burst_active(burst_active)
);

// [tbpc_panel_ctrl_bench.sv]
// self-checking bench for the transient burst panel control
`timescale 1ns/1ps
module tbpc_panel_ctrl_bench;
    import tbpc_pkg::*;
    typedef struct {logic [31:0] d; logic e;} tbpc_note_t;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, seed = 32'h0000004e;
    logic pready, pslverr;
    wire [15:0] lamps;
    assign lamps[7:5] = 3'h0; // unused status positions
    logic [12:0] op_req = 13'h0, btn;
    logic e_run, e_pos, e_byp;
    logic [3:0] e_lead, e_rate;
    tbpc_note_t note_q[$], cur;
    int err_count = 0, checks = 0, cycles = 0, n;
    int seq[] = '{1, 2, 3, 5, 7, 6, 8, 6, 8, 8, 6, 4, 2, 2, 3, 3, 9, 10, 11, 12};

    always #5 pclk = ~pclk;

    tbpc_operator u_tbpc_operator (.pclk(pclk), .presetn(presetn), .press_req(op_req), .btn(btn));

    tbpc_panel_ctrl #(.SAFETY_LIMIT(1000)) u_tbpc_panel_ctrl (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .run_btn(btn[0]), .stop_btn(btn[1]), .polarity_btn(btn[2]), .bypass_btn(btn[3]),
        .reset_btn(btn[4]), .line_btn(btn[5]), .neutral_btn(btn[6]), .earth_btn(btn[7]),
        .cable_btn(btn[8]), .rate_btn(btn[12:9]), .run_lamp(lamps[0]), .stop_lamp(lamps[1]),
        .pos_lamp(lamps[2]), .neg_lamp(lamps[3]), .bypass_lamp(lamps[4]),
        .rate_lamp(lamps[15:12]), .line_relay(lamps[8]), .neutral_relay(lamps[9]),
        .earth_lead_select(lamps[10]), .cable_port_select(lamps[11]), .polarity_neg(),
        .pulse_trigger(), .burst_active()
    );

    // xorshift source of random data
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd

    // expected status word from the bench model
    function automatic logic [31:0] exp_st();
        return {15'h0, e_run, e_rate, e_lead, 3'h0, e_byp, !e_pos, e_pos, !e_run, e_run};
    endfunction : exp_st

    task automatic defaults();
        e_run = 1'b0;
        e_pos = 1'b1;
        e_byp = 1'b0;
        e_lead = 4'h0;
        e_rate = 4'h1;
    endtask : defaults

    // one apb transfer, held until pready is sampled high
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rd(input logic [11:0] a, input logic [31:0] d, input logic e);
        note_q.push_back('{d, e});
        apb(1'b0, a, 32'h0);
    endtask : rd

    task automatic check();
        rd(12'h004, exp_st(), 1'b0);
    endtask : check

    // press one button through the operator and update the model
    task automatic press(input int idx);
        @(posedge pclk);
        op_req <= 13'(1) << idx;
        @(posedge pclk);
        op_req <= 13'h0;
        repeat (10) @(posedge pclk);
        case (idx)
            0: e_run = 1'b1;
            1: e_run = 1'b0;
            2: e_pos = !e_pos;
            3: e_byp = !e_byp;
            4: defaults();
            5, 6, 7: e_lead = (e_lead & 4'h7) ^ (4'(1) << (idx - 5));
            8: e_lead = e_lead[3] ? 4'h0 : 4'h8;
            default: e_rate = 4'(1) << (idx - 9);
        endcase
    endtask : press

    task automatic print_verdict();
        $display("checks %0d errors %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : print_verdict

    // ------------------------------------------------------------
    // result watcher: oldest note against each completed read
    // ------------------------------------------------------------
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1 && !pwrite && note_q.size() > 0) begin
            cur = note_q.pop_front();
            checks++;
            if (prdata !== cur.d || pslverr !== cur.e) begin
                err_count++;
                $display("[FAIL] %0t read %h err %b, want %h err %b", $time, prdata,
                    pslverr, cur.d, cur.e);
            end
            if (!cur.e && lamps !== cur.d[15:0]) begin
                err_count++;
                $display("[FAIL] %0t lamps %h, want %h", $time, lamps, cur.d[15:0]);
            end
        end
    end

    // hang guard
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 20000) begin
            err_count++;
            print_verdict();
        end
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        defaults();
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        check();
        foreach (seq[i]) begin
            press(seq[i]);
            check();
        end
        n = int'(rnd() % 4) + 1;
        repeat (n) press(2);
        check();
        apb(1'b1, 12'h004, rnd());
        check();
        rd(12'h008, 32'h0, 1'b1);
        press(0);
        check();
        repeat (880) @(posedge pclk);
        check();
        repeat (200) @(posedge pclk);
        e_run = 1'b0;
        check();
        press(0);
        repeat (880) @(posedge pclk);
        check();
        press(1);
        check();
        press(3);
        press(0);
        repeat (1500) @(posedge pclk);
        check();
        apb(1'b1, 12'h000, 32'h00000010);
        defaults();
        check();
        apb(1'b1, 12'h000, 32'h00000001);
        e_run = 1'b1;
        check();
        apb(1'b1, 12'h000, 32'h00000002);
        e_run = 1'b0;
        check();
        apb(1'b1, 12'h000, 32'h0000240c);
        {e_pos, e_byp, e_lead, e_rate} = {1'b0, 1'b1, 4'h4, 4'h2};
        check();
        apb(1'b1, 12'h000, 32'h00000800);
        e_lead = 4'h8;
        check();
        print_verdict();
    end
endmodule : tbpc_panel_ctrl_bench
